// *** wdcf_pkg.sv ***
package wdcf_pkg;

  // Configuration word layout, bit 11 down to bit 0
  typedef struct packed {
    logic [8:0] code_protect_fuse;       // Bits 11..3, low means protected
    logic       watchdog_enable_fuse;    // Bit 2
    logic [1:0] oscillator_type_select;  // Bits 1..0
  } wdcf_cfg_t;

  // Low four bits of the option register
  typedef struct packed {
    logic       prescaler_assign_select; // 1 = watchdog, 0 = Timer0
    logic [2:0] prescale_ratio_select;
  } wdcf_opt_t;

  // Oscillator type codes
  localparam logic [1:0] OSC_LOW_POWER_CRYSTAL  = 2'h0;
  localparam logic [1:0] OSC_STANDARD_CRYSTAL   = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED_CRYSTAL = 2'h2;
  localparam logic [1:0] OSC_RC                 = 2'h3;

  // Field widths and positions
  localparam int          CP_WIDTH       = 9;
  localparam logic [8:0]  CP_ALL_OFF     = 9'h1FF;
  localparam logic [8:0]  CP_OLD_MASK    = 9'h001;  // Older parts keep only bit 3
  localparam logic        PSA_TIMER0     = 1'b0;
  localparam logic        PSA_WATCHDOG   = 1'b1;
  localparam logic        FUSE_ENABLED   = 1'b1;
  localparam logic [7:0]  PRESC_ONE      = 8'h01;
  localparam logic [7:0]  PRESC_ZERO     = 8'h00;

  // Reset values
  localparam wdcf_cfg_t   CFG_RESET      = 12'hFFF;
  localparam logic        FLAG_N_IDLE    = 1'b1;

  // Timing: clock rate, watchdog oscillator rate and nominal periods
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned WDT_OSC_HZ     = 1_000_000;
  localparam int unsigned WDT_PERIOD_MS  = 18;
  localparam int unsigned DRT_PERIOD_MS  = 18;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned WDT_BASE_TICKS = WDT_PERIOD_MS * WDT_OSC_HZ / MS_PER_S;
  localparam int unsigned DRT_CYCLES     = DRT_PERIOD_MS * CLK_HZ / MS_PER_S;
  localparam int          WDT_CNT_W      = 15;
  localparam int          DRT_CNT_W      = 21;
  localparam int          PRESC_W        = 8;

  // Device state, Gray along reset -> run -> sleep
  typedef enum logic [1:0] {
    WDCF_ST_RESET = 2'b00,
    WDCF_ST_RUN   = 2'b01,
    WDCF_ST_SLEEP = 2'b11
  } wdcf_state_t;

endpackage

// *** wdcf_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a level from another clock
module wdcf_sync (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// *** wdcf_watchdog.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Only the enable fuse can stop the watchdog
// - Enable fuse at bit 2, one enables
// - Bits 1..0 pick the oscillator type
// - Newer parts: bits 11..3 protect, zero protects
// - Older parts: bit 3 protects, upper bits zero
// - Watchdog counts its own RC oscillator
// - Watchdog keeps counting during sleep
// - Time-out forces full device reset, wakes sleep
// - Watchdog reset clears the time-out flag
// - Undivided time-out is nominally 18 ms
// - Postscaler stretches time-out up to 1:128
// - One 8-bit counter shared by both users
// - Counter serves one user at a time
// - Option low nibble sets assignment and ratio
// - Power-up delay holds reset for 18 ms
// - Sleep ends only by reset or time-out
// - Assign bit low Timer0, high watchdog
// - Clear instruction zeroes count and postscaler
// - Sleep entry zeroes count and postscaler
module wdcf_watchdog
  import wdcf_pkg::*;
#(
  parameter int unsigned WDT_TICKS  = WDT_BASE_TICKS,
  parameter int unsigned DRT_CYCLES_P = DRT_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire wdcf_cfg_t  config_word_i,
  input  wire logic       new_variant_i,
  input  wire wdcf_opt_t  option_i,
  input  wire logic       watchdog_clear_instruction_i,
  input  wire logic       sleep_instruction_i,
  input  wire logic       wdt_osc_i,
  input  wire logic       tmr0_source_i,
  input  wire logic       tmr0_write_i,
  output wdcf_cfg_t       config_view_o,
  output logic            watchdog_enabled_o,
  output logic [1:0]      oscillator_type_select_o,
  output logic            code_protect_on_o,
  output logic            device_reset_o,
  output logic            sleeping_o,
  output logic            timeout_flag_n_o,
  output logic            power_down_flag_n_o,
  output logic            tmr0_increment_o
);

  wdcf_state_t            state_r;
  wdcf_state_t            state_nxt;
  logic [WDT_CNT_W-1:0]   base_cnt_r;
  logic [DRT_CNT_W-1:0]   drt_cnt_r;
  logic [PRESC_W-1:0]     presc_r;
  logic                   osc_s;
  logic                   osc_d_r;
  logic                   osc_tick;
  logic                   base_ovf;
  logic                   timeout;
  logic                   wdt_clear;
  logic                   enter_sleep;
  logic                   psa_wdt;
  logic [PRESC_W-1:0]     wdt_mask;
  logic [PRESC_W-1:0]     tmr0_mask;
  logic                   tmr0_div_hit;

  localparam logic [WDT_CNT_W-1:0] BASE_LAST = WDT_CNT_W'(WDT_TICKS - 1);
  localparam logic [DRT_CNT_W-1:0] DRT_LOAD  = DRT_CNT_W'(DRT_CYCLES_P - 1);
  localparam logic [DRT_CNT_W-1:0] DRT_DONE  = '0;
  localparam int                   CP_KEEP_BIT = 0;  // Older parts keep only the lowest protect bit

  // Watchdog oscillator is a foreign clock: synchronise, then edge detect
  wdcf_sync u_osc_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (wdt_osc_i),
    .q_o    (osc_s)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_s;
    end
  end

  assign osc_tick = osc_s & ~osc_d_r;

  // Fuse word view; older parts read zero above the single protect bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      config_view_o <= CFG_RESET;
    end else begin
      config_view_o.watchdog_enable_fuse   <= config_word_i.watchdog_enable_fuse;
      config_view_o.oscillator_type_select <= config_word_i.oscillator_type_select;
      if (new_variant_i) begin
        config_view_o.code_protect_fuse <= config_word_i.code_protect_fuse;
      end else begin
        config_view_o.code_protect_fuse <= config_word_i.code_protect_fuse & CP_OLD_MASK;
      end
    end
  end

  // Decoded fuse outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_enabled_o       <= FUSE_ENABLED;
      oscillator_type_select_o <= OSC_RC;
      code_protect_on_o        <= 1'b0;
    end else begin
      watchdog_enabled_o       <= config_word_i.watchdog_enable_fuse;
      oscillator_type_select_o <= config_word_i.oscillator_type_select;
      if (new_variant_i) begin
        code_protect_on_o <= (config_word_i.code_protect_fuse != CP_ALL_OFF);
      end else begin
        code_protect_on_o <= ~config_word_i.code_protect_fuse[CP_KEEP_BIT];
      end
    end
  end

  // Shared counter assignment and ratio masks
  assign psa_wdt   = (option_i.prescaler_assign_select == PSA_WATCHDOG);
  assign wdt_mask  = PRESC_W'((PRESC_ONE << option_i.prescale_ratio_select) - PRESC_ONE);
  assign tmr0_mask = PRESC_W'(((PRESC_ONE << option_i.prescale_ratio_select) << 1) - PRESC_ONE);
  assign tmr0_div_hit = ((presc_r & tmr0_mask) == tmr0_mask);

  // Time-out: no run-time input can mask it, only the fuse
  assign base_ovf = osc_tick && (base_cnt_r == BASE_LAST);
  assign timeout  = watchdog_enabled_o && (state_r != WDCF_ST_RESET) && base_ovf
                    && (!psa_wdt || ((presc_r & wdt_mask) == wdt_mask));

  assign enter_sleep = sleep_instruction_i && (state_r == WDCF_ST_RUN);
  assign wdt_clear   = (watchdog_clear_instruction_i && (state_r == WDCF_ST_RUN)) || enter_sleep;

  // Base watchdog count; runs in run and sleep alike
  always_ff @(posedge clk_i) begin
    if (srst_i || timeout || state_r == WDCF_ST_RESET) begin
      base_cnt_r <= '0;
    end else if (wdt_clear) begin
      base_cnt_r <= '0;
    end else if (osc_tick) begin
      if (base_ovf) begin
        base_cnt_r <= '0;
      end else begin
        base_cnt_r <= base_cnt_r + 1'b1;
      end
    end
  end

  // The one 8-bit counter: Timer0 prescaler or watchdog postscaler
  always_ff @(posedge clk_i) begin
    if (srst_i || state_r == WDCF_ST_RESET) begin
      presc_r <= PRESC_ZERO;
    end else if (psa_wdt) begin
      if (timeout || wdt_clear) begin
        presc_r <= PRESC_ZERO;
      end else if (base_ovf) begin
        presc_r <= presc_r + 1'b1;
      end
    end else begin
      if (tmr0_write_i) begin
        presc_r <= PRESC_ZERO;
      end else if (tmr0_source_i) begin
        presc_r <= presc_r + 1'b1;
      end
    end
  end

  // Timer0 increment: divided only while it owns the counter
  always_ff @(posedge clk_i) begin
    if (srst_i || state_r == WDCF_ST_RESET) begin
      tmr0_increment_o <= 1'b0;
    end else if (psa_wdt) begin
      tmr0_increment_o <= tmr0_source_i;
    end else begin
      tmr0_increment_o <= tmr0_source_i && !tmr0_write_i && tmr0_div_hit;
    end
  end

  // Device state: sleep is left only by a reset source
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WDCF_ST_RESET: begin
        if (drt_cnt_r == DRT_DONE) begin
          state_nxt = WDCF_ST_RUN;
        end
      end
      WDCF_ST_RUN: begin
        if (timeout) begin
          state_nxt = WDCF_ST_RESET;
        end else if (enter_sleep) begin
          state_nxt = WDCF_ST_SLEEP;
        end
      end
      WDCF_ST_SLEEP: begin
        if (timeout) begin
          state_nxt = WDCF_ST_RESET;
        end
      end
      default: begin
        state_nxt = WDCF_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= WDCF_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power-up delay; a time-out also reruns it so the oscillator settles
  always_ff @(posedge clk_i) begin
    if (srst_i || timeout) begin
      drt_cnt_r <= DRT_LOAD;
    end else if (state_r == WDCF_ST_RESET && drt_cnt_r != DRT_DONE) begin
      drt_cnt_r <= drt_cnt_r - 1'b1;
    end
  end

  // Reset and sleep status outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      device_reset_o <= 1'b1;
      sleeping_o     <= 1'b0;
    end else begin
      device_reset_o <= (state_nxt == WDCF_ST_RESET);
      sleeping_o     <= (state_nxt == WDCF_ST_SLEEP);
    end
  end

  // Cause flags; the time-out wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timeout_flag_n_o    <= FLAG_N_IDLE;
      power_down_flag_n_o <= FLAG_N_IDLE;
    end else if (timeout) begin
      timeout_flag_n_o <= 1'b0;
    end else if (enter_sleep) begin
      timeout_flag_n_o    <= FLAG_N_IDLE;
      power_down_flag_n_o <= 1'b0;
    end else if (watchdog_clear_instruction_i && state_r == WDCF_ST_RUN) begin
      timeout_flag_n_o    <= FLAG_N_IDLE;
      power_down_flag_n_o <= FLAG_N_IDLE;
    end
  end

  // Reference tick count since the last clear, kept apart from the real counters
  // Option change or fuse off voids it: the shared counter no longer starts at zero
  localparam int               REF_W    = WDT_CNT_W + PRESC_W;
  localparam logic [REF_W-1:0] REF_BASE = REF_W'(WDT_TICKS);
  localparam logic [REF_W-1:0] REF_ONE  = REF_W'(1);
  logic [REF_W-1:0]            ref_ticks_r;
  logic [REF_W-1:0]            ref_period;
  logic                        ref_valid_r;
  wdcf_opt_t                   ref_opt_r;

  // Expected period in watchdog ticks for the current option
  assign ref_period = psa_wdt ? (REF_BASE << option_i.prescale_ratio_select) : REF_BASE;

  always_ff @(posedge clk_i) begin
    if (srst_i || state_r == WDCF_ST_RESET || wdt_clear || timeout) begin
      ref_ticks_r <= '0;
      ref_valid_r <= 1'b1;
      ref_opt_r   <= option_i;
    end else begin
      if (osc_tick) begin
        ref_ticks_r <= ref_ticks_r + REF_ONE;
      end
      if (option_i != ref_opt_r || !watchdog_enabled_o) begin
        ref_valid_r <= 1'b0;
      end
    end
  end

  // Checks
  a_fuse_off_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    !watchdog_enabled_o && state_r != WDCF_ST_RESET |=> !device_reset_o)
    else $error("time-out with fuse off");
  a_fuse_bit_two: assert property (@(posedge clk_i) disable iff (srst_i)
    watchdog_enabled_o == config_view_o.watchdog_enable_fuse) else $error("enable not bit 2");
  a_osc_type: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> oscillator_type_select_o == $past(config_word_i.oscillator_type_select))
    else $error("oscillator type wrong");
  a_cp_new: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) && $past(new_variant_i)
    |-> code_protect_on_o == ($past(config_word_i.code_protect_fuse) != CP_ALL_OFF))
    else $error("protect decode wrong");
  a_timeout_resets: assert property (@(posedge clk_i) disable iff (srst_i)
    timeout |=> device_reset_o && !timeout_flag_n_o && !sleeping_o) else $error("time-out no reset");
  a_flag_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    !timeout_flag_n_o && state_r == WDCF_ST_RESET |=> !timeout_flag_n_o) else $error("flag lost");
  a_base_period: assert property (@(posedge clk_i) disable iff (srst_i)
    timeout && ref_valid_r && !psa_wdt |-> ref_ticks_r == REF_BASE - REF_ONE)
    else $error("base period wrong");
  a_post_ratio: assert property (@(posedge clk_i) disable iff (srst_i)
    timeout && ref_valid_r && psa_wdt |-> ref_ticks_r == ref_period - REF_ONE)
    else $error("postscale wrong");
  a_timeout_due: assert property (@(posedge clk_i) disable iff (srst_i)
    watchdog_enabled_o && ref_valid_r && option_i == ref_opt_r && state_r != WDCF_ST_RESET
    && osc_tick && ref_ticks_r == ref_period - REF_ONE |-> timeout)
    else $error("time-out missing");
  a_sleep_held: assert property (@(posedge clk_i) disable iff (srst_i)
    state_r == WDCF_ST_SLEEP && !timeout |=> state_r == WDCF_ST_SLEEP) else $error("left sleep");
  a_sleep_counts: assert property (@(posedge clk_i) disable iff (srst_i)
    state_r == WDCF_ST_SLEEP && osc_tick && !base_ovf |=> base_cnt_r == $past(base_cnt_r) + 1'b1)
    else $error("count stopped in sleep");
  a_clear_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    wdt_clear && !timeout |=> base_cnt_r == '0 && (!psa_wdt || presc_r == PRESC_ZERO))
    else $error("clear missed");
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (srst_i)
    enter_sleep && !timeout |=> sleeping_o && !power_down_flag_n_o) else $error("sleep entry");
  a_drt_hold: assert property (@(posedge clk_i)
    srst_i ##1 !srst_i |-> device_reset_o [*8]) else $error("delay too short");
  a_old_upper_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(new_variant_i) |-> config_view_o.code_protect_fuse[CP_WIDTH-1:CP_KEEP_BIT+1] == '0)
    else $error("old upper bits set");
  a_tmr0_undiv: assert property (@(posedge clk_i) disable iff (srst_i)
    psa_wdt && tmr0_source_i && state_r != WDCF_ST_RESET |=> tmr0_increment_o)
    else $error("Timer0 divided");

  c_timeout_run: cover property (@(posedge clk_i) state_r == WDCF_ST_RUN && timeout);
  c_timeout_sleep: cover property (@(posedge clk_i) state_r == WDCF_ST_SLEEP && timeout);
  c_clear_run: cover property (@(posedge clk_i) watchdog_clear_instruction_i && state_r == WDCF_ST_RUN);
  c_tmr0_div: cover property (@(posedge clk_i) !psa_wdt && tmr0_increment_o);
  c_fuse_off_tick: cover property (@(posedge clk_i) !watchdog_enabled_o && base_ovf);

endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb_top
  import wdcf_pkg::*;
;
  localparam int unsigned T = 4;     // Shortened watchdog base count
  localparam int unsigned D = 16;    // Shortened power-up delay
  localparam logic [27:0] M_ALL  = 28'hFFFFFFF;

  logic       clk_i;
  logic       srst_i;
  wdcf_cfg_t  cfg;
  logic       nv;
  wdcf_opt_t  opt;
  logic       clr;
  logic       slp;
  logic       osc;
  logic       src;
  logic       wr;
  wdcf_cfg_t  view;
  logic       wen;
  logic [1:0] ost;
  logic       cpon;
  logic       rst_o;
  logic       sleep_o;
  logic       to_n;
  logic       pd_n;
  logic       inc;
  logic [7:0] inc_cnt;
  logic [7:0] exp_inc;
  int         n_fail;
  int         tests_run;
  int         seed;
  logic [27:0] exp_q[$];
  logic [27:0] msk_q[$];
  event       chk_ev;

  wdcf_watchdog #(.WDT_TICKS(T), .DRT_CYCLES_P(D)) wdcf_watchdog_inst (
    .clk_i                        (clk_i),
    .srst_i                       (srst_i),
    .config_word_i                (cfg),
    .new_variant_i                (nv),
    .option_i                     (opt),
    .watchdog_clear_instruction_i (clr),
    .sleep_instruction_i          (slp),
    .wdt_osc_i                    (osc),
    .tmr0_source_i                (src),
    .tmr0_write_i                 (wr),
    .config_view_o                (view),
    .watchdog_enabled_o           (wen),
    .oscillator_type_select_o     (ost),
    .code_protect_on_o            (cpon),
    .device_reset_o               (rst_o),
    .sleeping_o                   (sleep_o),
    .timeout_flag_n_o             (to_n),
    .power_down_flag_n_o          (pd_n),
    .tmr0_increment_o             (inc)
  );

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Expected snapshot; older parts read bits 11..4 as zero
  function automatic logic [27:0] exp_of(input logic [3:0] st);
    wdcf_cfg_t v;
    logic      p;
    v = nv ? cfg : wdcf_cfg_t'({8'h00, cfg.code_protect_fuse[0], cfg.watchdog_enable_fuse, cfg.oscillator_type_select});
    p = nv ? (cfg.code_protect_fuse !== CP_ALL_OFF) : ~cfg.code_protect_fuse[0];
    return {exp_inc, v, cfg.watchdog_enable_fuse, cfg.oscillator_type_select, p, st};
  endfunction

  // Counts Timer0 increments on the edge after each pulse, clear of the compare
  always @(posedge clk_i) begin
    if (srst_i === 1'b1) begin
      inc_cnt <= 8'h00;
    end else if (inc === 1'b1) begin
      inc_cnt <= inc_cnt + 8'h01;
    end
  end

  // Monitor takes the oldest note when a snapshot is requested
  always begin
    logic [27:0] e;
    logic [27:0] m;
    @(chk_ev);
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    `CHK({inc_cnt, view, wen, ost, cpon, rst_o, sleep_o, to_n, pd_n} & m, e & m)
  end

  task automatic expect_st(input logic [3:0] st, input logic [27:0] m);
    exp_q.push_back(exp_of(st));
    msk_q.push_back(m);
    ->chk_ev;
  endtask

  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One-cycle instruction pulses: clear, sleep, source, write
  task automatic pulse(input logic [3:0] p);
    @(negedge clk_i);
    {clr, slp, src, wr} = p;
    @(negedge clk_i);
    {clr, slp, src, wr} = 4'h0;
  endtask

  // Watchdog RC edges, slow against the main clock
  task automatic osc_edges(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk_i);
      osc = 1'b1;
      repeat (5) @(negedge clk_i);
      osc = 1'b0;
      repeat (4) @(negedge clk_i);
    end
  endtask

  task automatic wait_rst_low(input int lim);
    int i;
    for (i = 0; i < lim && rst_o !== 1'b0; i++) @(negedge clk_i);
    if (rst_o !== 1'b0) begin
      n_fail++;
      finish_test();
    end
  endtask

  initial begin
    int n;
    seed = 61898;
    n_fail = 0;
    tests_run = 0;
    exp_inc = 8'h00;
    {clr, slp, src, wr, osc} = 5'h00;
    cfg = CFG_RESET;
    nv = 1'b1;
    opt = wdcf_opt_t'(4'h0);
    srst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    // Delay timer still holding after 14 cycles
    repeat (14) @(negedge clk_i);
    expect_st(4'b1011, M_ALL);
    wait_rst_low(10);
    expect_st(4'b0011, M_ALL);
    // Fuse decoding for both variants, every oscillator code
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_i);
      cfg = wdcf_cfg_t'(12'($random(seed)));
      cfg.oscillator_type_select = i[1:0];
      nv = i[2] ^ 1'($random(seed));
      repeat (2) @(negedge clk_i);
      expect_st(4'b0011, M_ALL);
    end
    cfg = CFG_RESET;
    nv = 1'b1;
    // Time-out count for every ratio, then undivided
    for (int r = 0; r < 9; r++) begin
      opt = (r == 8) ? wdcf_opt_t'(4'h0) : wdcf_opt_t'({1'b1, r[2:0]});
      n = (r == 8) ? T : (T << r);
      pulse(4'h8);
      osc_edges(n - 1);
      expect_st(4'b0011, M_ALL);
      osc_edges(1);
      expect_st(4'b1001, M_ALL);
      wait_rst_low(40);
      pulse(4'h8);
      expect_st(4'b0011, M_ALL);
    end
    // Clear before expiry, undivided and divided
    for (int r = 0; r < 2; r++) begin
      opt = wdcf_opt_t'({r[0], 3'h1});
      n = r ? 2 * T : T;
      // Clear first: a change of owner mid-count leaves the shared counter dirty
      pulse(4'h8);
      osc_edges(n - 1);
      pulse(4'h8);
      osc_edges(n - 1);
      expect_st(4'b0011, M_ALL);
    end
    // Sleep restarts the count; time-out wakes the device
    opt = wdcf_opt_t'(4'h9);
    pulse(4'h8);
    osc_edges(5);
    pulse(4'h4);
    expect_st(4'b0110, M_ALL);
    osc_edges(2 * T - 1);
    expect_st(4'b0110, M_ALL);
    osc_edges(1);
    expect_st(4'b1000, M_ALL);
    wait_rst_low(40);
    pulse(4'h8);
    expect_st(4'b0011, M_ALL);
    // External reset also ends sleep
    pulse(4'h4);
    expect_st(4'b0110, M_ALL);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    wait_rst_low(40);
    expect_st(4'b0011, M_ALL);
    // Fuse off: nothing stops or trips it at run time
    cfg.watchdog_enable_fuse = 1'b0;
    opt = wdcf_opt_t'(4'h0);
    osc_edges(3 * T);
    expect_st(4'b0011, M_ALL);
    cfg = CFG_RESET;
    pulse(4'h8);
    // Timer0 owns the counter: 1:2 up to 1:256
    for (int r = 0; r < 8; r++) begin
      opt = wdcf_opt_t'({1'b0, r[2:0]});
      pulse(4'h1);
      repeat (4 << r) pulse(4'h2);
      exp_inc = exp_inc + 8'h02;
      @(negedge clk_i);
      expect_st(4'b0011, M_ALL);
    end
    // Watchdog owns it: Timer0 counts every source
    opt = wdcf_opt_t'(4'hF);
    repeat (5) pulse(4'h2);
    exp_inc = exp_inc + 8'h05;
    repeat (2) @(negedge clk_i);
    expect_st(4'b0011, M_ALL);
    repeat (4) @(negedge clk_i);
    finish_test();
  end
endmodule
